// ---- stpc_cfg.svh ----
/*
 * Offsets, field positions, reset values and fixed codes of the status,
 * trigger and protection core. Assumes a 32-bit APB with byte addresses.
 */
// Functional notes
// - Falling-edge mask bit set: a 1-to-0 condition change latches an event.
// - Rising-edge mask bit set: a 0-to-1 condition change latches an event.
// - Both mask bits set: any change of that condition bit latches an event.
// - Both mask bits clear: no change of that bit ever latches an event.
// - Writing an edge mask may itself latch rising or falling events.
// - Edge masks accept 0 to 32727 and reset to zero.
// - Errors queue in arrival order; each read removes the oldest error.
// - Reading an empty error queue returns code zero, meaning no error.
// - Queue overflow replaces the final stored entry with code -350.
// - Front-panel errors bypass the remote queue and go to the display.
// - A trigger while armed moves pending voltage and current to output.
// - Accepting a trigger clears the waiting-for-trigger flag.
// - Continuous arming re-arms after each trigger and sets the flag again.
// - The bus is the only trigger source, also after reset.
// - Pending levels survive immediate writes until trigger or abort.
// - With nothing pending, the triggered level reads as the immediate one.
// - A trigger applies pending levels only when armed first, by an arm command or by continuous arming.
// - Output above the overvoltage limit disables output and sets the flag.
// - Protection clear removes the trip only once the cause is gone.
// - Overvoltage trip acts at once, ignoring the protection delay.
// - The event word holds events until read; a read returns and clears it.
// - The overvoltage flag is bit weight 1 of the questionable condition.
// - The waiting-for-trigger flag is bit weight 32 of operation condition.
// - Summary bit 3 is the OR of enabled questionable event bits.
`ifndef STPC_CFG_SVH
`define STPC_CFG_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define STPC_CMD_OFS 12'h000
`define STPC_CONFIG_OFS 12'h004
`define STPC_TRIG_SRC_OFS 12'h008
`define STPC_QUESTIONABLE_SUMMARY_COND_OFS 12'h00c
`define STPC_QUESTIONABLE_SUMMARY_EVENT_OFS 12'h010
`define STPC_QUESTIONABLE_SUMMARY_ENABLE_OFS 12'h014
`define STPC_RISE_MASK_OFS 12'h018
`define STPC_FALL_MASK_OFS 12'h01c
`define STPC_OPER_COND_OFS 12'h020
`define STPC_STATUS_BYTE_OFS 12'h024
`define STPC_VOLT_IMM_OFS 12'h028
`define STPC_PENDING_VOLTAGE_LEVEL_OFS 12'h02c
`define STPC_CURR_IMM_OFS 12'h030
`define STPC_PENDING_CURRENT_LEVEL_OFS 12'h034
`define STPC_OV_LIMIT_OFS 12'h038
`define STPC_ERR_QUEUE_OFS 12'h03c
`define STPC_PROT_DELAY_OFS 12'h040

// ****************************************************************
// Fields, limits and codes
// ****************************************************************
`define STPC_CMD_ARM_BIT 0
`define STPC_CMD_TRIGGER_BIT 1
`define STPC_CMD_ABORT_BIT 2
`define STPC_CMD_PROT_CLEAR_BIT 3
`define STPC_CFG_CONT_BIT 0
`define STPC_CFG_OUTPUT_BIT 1
`define STPC_OV_BIT 0
`define STPC_WTG_BIT 5
`define STPC_QUESTIONABLE_SUMMARY_SUM_BIT 3
`define STPC_MASK_MAX 16'h7fd7
`define STPC_TRIG_SRC_BUS 16'h0000
`define STPC_ERR_NONE 16'h0000
`define STPC_ERR_OVERFLOW 16'hfea2
`define STPC_LEVEL_RST 16'h0000
`define STPC_OV_LIMIT_RST 16'hffff
`define STPC_PROT_DELAY_RST 16'h00c8

`endif

// ---- stpc_core.sv ----
/*
 * Status, trigger and overvoltage core of a programmable supply, an APB
 * slave. Assumes the questionable condition pins are asynchronous, while
 * the measured voltage and error reports come from logic on i_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "stpc_cfg.svh"

module stpc_core #(
  parameter int ERR_DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic [15:1] i_questionable_summary_cond,
  input wire logic [15:0] i_meas_volt,
  input wire logic i_err_valid,
  input wire logic [15:0] i_err_code,
  input wire logic i_err_local,
  output logic [15:0] o_volt_set,
  output logic [15:0] o_curr_set,
  output logic o_output_on,
  output logic o_questionable_summary,
  output logic o_local_err_valid,
  output logic [15:0] o_local_err
);

  localparam int PW = $clog2(ERR_DEPTH);

  // Refused at elaboration: one slot leaves no room for the overflow code.
  if (ERR_DEPTH < 2) begin : g_depth_check
    $error("ERR_DEPTH must be at least two");
  end


  // ****************************************************************
  // State
  // ****************************************************************
  stpc_pkg::stpc_state_type s_r;
  stpc_pkg::stpc_state_type s_nxt;
  logic [15:0] err_mem [ERR_DEPTH];
  logic [PW-1:0] rd_ptr_r;
  logic [PW-1:0] wr_ptr_r;
  logic [PW:0] cnt_r;

  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic addr_ok;
  logic val_ok;
  logic [15:0] wd;
  logic [15:0] cond_now;
  logic [15:0] rise_hits;
  logic [15:0] fall_hits;
  logic [15:0] new_events;
  logic waiting_for_trigger_flag;
  logic arm_cmd;
  logic trig_cmd;
  logic abort_cmd;
  logic clr_cmd;
  logic trig_take;
  logic over_limit;
  logic push;
  logic pop;
  logic q_full;
  logic q_empty;

  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] o);
    return a == o;
  endfunction

  assign setup = i_psel && !i_penable;
  assign access = i_psel && i_penable;
  assign wr = access && i_pwrite;
  assign rd = access && !i_pwrite;
  assign wd = i_pwdata[15:0];
  assign o_pready = access;
  assign o_pslverr = access && !(addr_ok && val_ok);
  assign o_prdata = s_r.rdata;
  assign waiting_for_trigger_flag = (s_r.trig == stpc_pkg::ST_ARMED);
  assign q_full = (cnt_r == (PW+1)'(ERR_DEPTH));
  assign q_empty = (cnt_r == '0);
  assign over_limit = i_meas_volt > s_r.ov_limit;

  // Masks above the documented maximum and any source but the bus fail.
  always_comb begin
    addr_ok = 1'b1;
    val_ok = 1'b1;
    if (is_addr(i_paddr, `STPC_CMD_OFS)) begin
      addr_ok = 1'b1;
    end else if (is_addr(i_paddr, `STPC_CONFIG_OFS)) begin
      addr_ok = 1'b1;
    end else if (is_addr(i_paddr, `STPC_TRIG_SRC_OFS)) begin
      val_ok = !i_pwrite || (wd == `STPC_TRIG_SRC_BUS);
    end else if (is_addr(i_paddr, `STPC_RISE_MASK_OFS) ||
                 is_addr(i_paddr, `STPC_FALL_MASK_OFS)) begin
      val_ok = !i_pwrite || (wd <= `STPC_MASK_MAX);
    end else if (is_addr(i_paddr, `STPC_QUESTIONABLE_SUMMARY_ENABLE_OFS)) begin
      val_ok = !i_pwrite || (wd <= `STPC_MASK_MAX);
    end else if ((i_paddr > `STPC_PROT_DELAY_OFS) ||
                 (i_paddr[1:0] != 2'h0)) begin
      addr_ok = 1'b0;
    end
  end

  assign arm_cmd = wr && addr_ok && is_addr(i_paddr, `STPC_CMD_OFS) &&
                   i_pwdata[`STPC_CMD_ARM_BIT];
  assign trig_cmd = wr && is_addr(i_paddr, `STPC_CMD_OFS) &&
                    i_pwdata[`STPC_CMD_TRIGGER_BIT];
  assign abort_cmd = wr && is_addr(i_paddr, `STPC_CMD_OFS) &&
                     i_pwdata[`STPC_CMD_ABORT_BIT];
  assign clr_cmd = wr && is_addr(i_paddr, `STPC_CMD_OFS) &&
                   i_pwdata[`STPC_CMD_PROT_CLEAR_BIT];
  assign trig_take = trig_cmd && waiting_for_trigger_flag;
  assign push = i_err_valid && !i_err_local;
  assign pop = rd && s_r.rd_pop;

  // ****************************************************************
  // Edge filters
  // ****************************************************************
  assign cond_now = s_r.cond;
  assign rise_hits = cond_now & ~s_r.cond_prev & s_r.rise_mask;
  assign fall_hits = ~cond_now & s_r.cond_prev & s_r.fall_mask;

  always_comb begin
    new_events = rise_hits | fall_hits;
    // A mask bit newly set against a condition already at its level
    // counts as that edge, as if the filter had just seen it happen.
    if (wr && val_ok && is_addr(i_paddr, `STPC_RISE_MASK_OFS)) begin
      new_events = new_events | (wd & ~s_r.rise_mask & cond_now);
    end
    if (wr && val_ok && is_addr(i_paddr, `STPC_FALL_MASK_OFS)) begin
      new_events = new_events | (wd & ~s_r.fall_mask & ~cond_now);
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.sync1 = {i_questionable_summary_cond, 1'b0};
    s_nxt.sync2 = s_r.sync1;
    s_nxt.sync3 = s_r.sync2;
    // A pin bit moves only once the second and third stages agree.
    s_nxt.cond = (s_r.sync2 & ~(s_r.sync2 ^ s_r.sync3)) |
                 (s_r.cond & (s_r.sync2 ^ s_r.sync3));
    s_nxt.cond[`STPC_OV_BIT] = s_r.ov_tripped;
    s_nxt.cond_prev = s_r.cond;
    // Only bits already returned by a read are cleared; new ones win.
    s_nxt.event_word = s_r.event_word | new_events;
    if (rd && is_addr(i_paddr, `STPC_QUESTIONABLE_SUMMARY_EVENT_OFS)) begin
      s_nxt.event_word = (s_r.event_word & ~s_r.rdata[15:0]) |
                         new_events;
    end
    s_nxt.local_err_valid = i_err_valid && i_err_local;
    if (i_err_valid && i_err_local) begin
      s_nxt.local_err = i_err_code;
    end

    // Overvoltage trips on the clock edge after it is seen, with no delay count.
    if (over_limit) begin
      s_nxt.ov_tripped = 1'b1;
    end else if (clr_cmd) begin
      s_nxt.ov_tripped = 1'b0;
    end

    if (wr && val_ok) begin
      if (is_addr(i_paddr, `STPC_CONFIG_OFS)) begin
        s_nxt.cont_arm = i_pwdata[`STPC_CFG_CONT_BIT];
        s_nxt.output_req = i_pwdata[`STPC_CFG_OUTPUT_BIT];
      end else if (is_addr(i_paddr, `STPC_QUESTIONABLE_SUMMARY_ENABLE_OFS)) begin
        s_nxt.enable_mask = wd;
      end else if (is_addr(i_paddr, `STPC_RISE_MASK_OFS)) begin
        s_nxt.rise_mask = wd;
      end else if (is_addr(i_paddr, `STPC_FALL_MASK_OFS)) begin
        s_nxt.fall_mask = wd;
      end else if (is_addr(i_paddr, `STPC_VOLT_IMM_OFS)) begin
        s_nxt.volt_imm = wd;
      end else if (is_addr(i_paddr, `STPC_CURR_IMM_OFS)) begin
        s_nxt.curr_imm = wd;
      end else if (is_addr(i_paddr, `STPC_PENDING_VOLTAGE_LEVEL_OFS)) begin
        if (!s_r.pend_valid) begin
          s_nxt.curr_pend = s_r.curr_imm;
        end
        s_nxt.volt_pend = wd;
        s_nxt.pend_valid = 1'b1;
      end else if (is_addr(i_paddr, `STPC_PENDING_CURRENT_LEVEL_OFS)) begin
        if (!s_r.pend_valid) begin
          s_nxt.volt_pend = s_r.volt_imm;
        end
        s_nxt.curr_pend = wd;
        s_nxt.pend_valid = 1'b1;
      end else if (is_addr(i_paddr, `STPC_OV_LIMIT_OFS)) begin
        s_nxt.ov_limit = wd;
      end else if (is_addr(i_paddr, `STPC_PROT_DELAY_OFS)) begin
        s_nxt.prot_delay = wd;
      end
    end

    // ****************************************************************
    // Trigger sequencer
    // ****************************************************************
    case (s_r.trig)
      stpc_pkg::ST_IDLE: begin
        if (arm_cmd || s_r.cont_arm) begin
          s_nxt.trig = stpc_pkg::ST_ARMED;
        end
      end
      stpc_pkg::ST_ARMED: begin
        if (abort_cmd) begin
          s_nxt.trig = stpc_pkg::ST_IDLE;
        end else if (trig_take) begin
          if (s_r.pend_valid) begin
            s_nxt.volt_imm = s_r.volt_pend;
            s_nxt.curr_imm = s_r.curr_pend;
            s_nxt.pend_valid = 1'b0;
          end
          s_nxt.trig = s_r.cont_arm ? stpc_pkg::ST_REARM
                                    : stpc_pkg::ST_IDLE;
        end
      end
      stpc_pkg::ST_REARM: begin
        s_nxt.trig = abort_cmd ? stpc_pkg::ST_IDLE
                               : stpc_pkg::ST_ARMED;
      end
      default: begin
        s_nxt.trig = stpc_pkg::ST_IDLE;
      end
    endcase
    if (abort_cmd) begin
      s_nxt.pend_valid = 1'b0;
    end

    // ****************************************************************
    // Read data, captured in the setup cycle
    // ****************************************************************
    if (setup) begin
      s_nxt.rdata = '0;
      s_nxt.rd_pop = 1'b0;
      if (is_addr(i_paddr, `STPC_CONFIG_OFS)) begin
        s_nxt.rdata[`STPC_CFG_CONT_BIT] = s_r.cont_arm;
        s_nxt.rdata[`STPC_CFG_OUTPUT_BIT] = s_r.output_req;
      end else if (is_addr(i_paddr, `STPC_TRIG_SRC_OFS)) begin
        s_nxt.rdata[15:0] = `STPC_TRIG_SRC_BUS;
      end else if (is_addr(i_paddr, `STPC_QUESTIONABLE_SUMMARY_COND_OFS)) begin
        s_nxt.rdata[15:0] = s_r.cond;
      end else if (is_addr(i_paddr, `STPC_QUESTIONABLE_SUMMARY_EVENT_OFS)) begin
        s_nxt.rdata[15:0] = s_r.event_word;
      end else if (is_addr(i_paddr, `STPC_QUESTIONABLE_SUMMARY_ENABLE_OFS)) begin
        s_nxt.rdata[15:0] = s_r.enable_mask;
      end else if (is_addr(i_paddr, `STPC_RISE_MASK_OFS)) begin
        s_nxt.rdata[15:0] = s_r.rise_mask;
      end else if (is_addr(i_paddr, `STPC_FALL_MASK_OFS)) begin
        s_nxt.rdata[15:0] = s_r.fall_mask;
      end else if (is_addr(i_paddr, `STPC_OPER_COND_OFS)) begin
        s_nxt.rdata[`STPC_WTG_BIT] = waiting_for_trigger_flag;
      end else if (is_addr(i_paddr, `STPC_STATUS_BYTE_OFS)) begin
        s_nxt.rdata[`STPC_QUESTIONABLE_SUMMARY_SUM_BIT] = o_questionable_summary;
      end else if (is_addr(i_paddr, `STPC_VOLT_IMM_OFS)) begin
        s_nxt.rdata[15:0] = s_r.volt_imm;
      end else if (is_addr(i_paddr, `STPC_CURR_IMM_OFS)) begin
        s_nxt.rdata[15:0] = s_r.curr_imm;
      end else if (is_addr(i_paddr, `STPC_PENDING_VOLTAGE_LEVEL_OFS)) begin
        s_nxt.rdata[15:0] = s_r.pend_valid ? s_r.volt_pend
                                           : s_r.volt_imm;
      end else if (is_addr(i_paddr, `STPC_PENDING_CURRENT_LEVEL_OFS)) begin
        s_nxt.rdata[15:0] = s_r.pend_valid ? s_r.curr_pend
                                           : s_r.curr_imm;
      end else if (is_addr(i_paddr, `STPC_OV_LIMIT_OFS)) begin
        s_nxt.rdata[15:0] = s_r.ov_limit;
      end else if (is_addr(i_paddr, `STPC_PROT_DELAY_OFS)) begin
        s_nxt.rdata[15:0] = s_r.prot_delay;
      end else if (is_addr(i_paddr, `STPC_ERR_QUEUE_OFS)) begin
        s_nxt.rdata[15:0] = q_empty ? `STPC_ERR_NONE
                                    : err_mem[rd_ptr_r];
        s_nxt.rd_pop = !q_empty && !i_pwrite;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_r <= '0;
      s_r.volt_imm <= `STPC_LEVEL_RST;
      s_r.curr_imm <= `STPC_LEVEL_RST;
      s_r.ov_limit <= `STPC_OV_LIMIT_RST;
      s_r.prot_delay <= `STPC_PROT_DELAY_RST;
      s_r.trig <= stpc_pkg::ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // Error queue
  // ****************************************************************
  // A full queue overwrites its newest slot, so the oldest errors stay.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_ptr_r <= '0;
      wr_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (pop) begin
        rd_ptr_r <= PW'((32'(rd_ptr_r) + 1) % ERR_DEPTH);
      end
      if (push && (!q_full || pop)) begin
        wr_ptr_r <= PW'((32'(wr_ptr_r) + 1) % ERR_DEPTH);
      end
      if (push && !q_full && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (push && (!q_full || pop)) begin
      err_mem[wr_ptr_r] <= i_err_code;
    end else if (push) begin
      err_mem[PW'((32'(wr_ptr_r) + ERR_DEPTH - 1) % ERR_DEPTH)] <=
        `STPC_ERR_OVERFLOW;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_volt_set = s_r.volt_imm;
  assign o_curr_set = s_r.curr_imm;
  assign o_output_on = s_r.output_req && !s_r.ov_tripped;
  assign o_questionable_summary = |(s_r.event_word & s_r.enable_mask);
  assign o_local_err_valid = s_r.local_err_valid;
  assign o_local_err = s_r.local_err;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic [15:0] quiet_bits;
  assign quiet_bits = ~(s_r.rise_mask | s_r.fall_mask);

  sequence s_trig_drop;
    !waiting_for_trigger_flag ##1 waiting_for_trigger_flag;
  endsequence

  property p_fall_event;
    @(posedge i_clk) disable iff (!i_nrst)
      (fall_hits != '0) |=> ((s_r.event_word & $past(fall_hits)) ==
                             $past(fall_hits));
  endproperty
  a_fall_event: assert property (p_fall_event) else $error("fall lost");

  property p_rise_event;
    @(posedge i_clk) disable iff (!i_nrst)
      (rise_hits != '0) |=> ((s_r.event_word & $past(rise_hits)) ==
                             $past(rise_hits));
  endproperty
  a_rise_event: assert property (p_rise_event) else $error("rise lost");

  property p_quiet_bits;
    @(posedge i_clk) disable iff (!i_nrst)
      ##1 ((s_r.event_word & ~$past(s_r.event_word) & $past(quiet_bits) &
            quiet_bits) == '0);
  endproperty
  a_quiet_bits: assert property (p_quiet_bits) else $error("quiet bit set");

  property p_event_read_clear;
    @(posedge i_clk) disable iff (!i_nrst)
      (rd && is_addr(i_paddr, `STPC_QUESTIONABLE_SUMMARY_EVENT_OFS) && new_events == '0) |=>
        ((s_r.event_word & $past(s_r.rdata[15:0])) == '0);
  endproperty
  a_event_read_clear: assert property (p_event_read_clear) else $error("no clear");

  property p_summary;
    @(posedge i_clk) disable iff (!i_nrst)
      o_questionable_summary == ((s_r.event_word & s_r.enable_mask) != '0);
  endproperty
  a_summary: assert property (p_summary) else $error("summary wrong");

  property p_empty_read;
    @(posedge i_clk) disable iff (!i_nrst)
      (setup && !i_pwrite && is_addr(i_paddr, `STPC_ERR_QUEUE_OFS) && q_empty)
        |=> (o_prdata == 32'h0000_0000 && !s_r.rd_pop);
  endproperty
  a_empty_read: assert property (p_empty_read) else $error("empty not zero");

  property p_pop_count;
    @(posedge i_clk) disable iff (!i_nrst)
      (pop && !push) |=> (cnt_r == $past(cnt_r) - 1'b1);
  endproperty
  a_pop_count: assert property (p_pop_count) else $error("pop lost");

  property p_trigger_apply;
    @(posedge i_clk) disable iff (!i_nrst)
      (trig_take && s_r.pend_valid && !abort_cmd) |=>
        (o_volt_set == $past(s_r.volt_pend) && !s_r.pend_valid);
  endproperty
  a_trigger_apply: assert property (p_trigger_apply) else $error("no apply");

  property p_idle_trigger;
    @(posedge i_clk) disable iff (!i_nrst)
      (trig_cmd && !waiting_for_trigger_flag) |=> $stable(o_volt_set);
  endproperty
  a_idle_trigger: assert property (p_idle_trigger) else $error("unarmed");

  property p_rearm;
    @(posedge i_clk) disable iff (!i_nrst)
      (trig_take && s_r.cont_arm && !abort_cmd) |=> s_trig_drop;
  endproperty
  a_rearm: assert property (p_rearm) else $error("no rearm");

  property p_ov_trip;
    @(posedge i_clk) disable iff (!i_nrst)
      over_limit |=> (!o_output_on && s_r.ov_tripped) ##1
                     s_r.cond[`STPC_OV_BIT];
  endproperty
  a_ov_trip: assert property (p_ov_trip) else $error("no trip");

endmodule // stpc_core

`default_nettype wire

// ---- stpc_pkg.sv ----
/*
 * Types of the status, trigger and protection core.
 * Assumes 16-bit status words and levels.
 */
package stpc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_REARM
  } stpc_trig_type;

  typedef struct packed {
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic [15:0] sync3;
    logic [15:0] cond;
    logic [15:0] cond_prev;
    logic [15:0] event_word;
    logic [15:0] enable_mask;
    logic [15:0] rise_mask;
    logic [15:0] fall_mask;
    logic [15:0] volt_imm;
    logic [15:0] curr_imm;
    logic [15:0] volt_pend;
    logic [15:0] curr_pend;
    logic pend_valid;
    logic [15:0] ov_limit;
    logic [15:0] prot_delay;
    logic ov_tripped;
    logic output_req;
    logic cont_arm;
    stpc_trig_type trig;
    logic [31:0] rdata;
    logic rd_pop;
    logic [15:0] local_err;
    logic local_err_valid;
  } stpc_state_type;

endpackage

// ---- stpc_plant_model.sv ----
/*
 * Model of the supply output stage that feeds the measured voltage back.
 * Assumes an active level and an output-on flag from the core, plus an
 * outside surge that the bench injects to provoke an overvoltage trip.
 */
`timescale 1ns/1ps
`default_nettype none

module stpc_plant_model (
  input wire logic i_clk,
  input wire logic i_on,
  input wire logic [15:0] i_set,
  input wire logic [15:0] i_surge,
  output logic [15:0] o_meas
);
  // ****************************************************************
  // Output stage
  // ****************************************************************
  // The surge stays when the output is off, so a trip cause can persist.
  always_ff @(posedge i_clk) begin
    o_meas <= (i_on ? i_set : 16'h0000) + i_surge;
  end
endmodule // stpc_plant_model

`default_nettype wire

// ---- tb.sv ----
/*
 * Self-checking bench of stpc_core: APB tasks and scripted sequences.
 * Assumes stpc_plant_model and a shortened error queue of four entries.
 */
`timescale 1ns/1ps
`default_nettype none
`include "stpc_cfg.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  $display("[FAIL] %s exp %h got %h", nm, e, g); n_errors++; end end

module tb;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, ev = 0, el = 0;
  logic pready, serr, se, on, qs, lv;
  logic [11:0] pa = 0;
  logic [31:0] pw = 0, prd, q;
  logic [15:1] qc = 0;
  logic [15:0] ec = 0, surge = 0, meas, vset, cset, le;
  int n_errors = 0, samples_checked = 0;
  always #12.5 clk = ~clk;
  stpc_core #(.ERR_DEPTH(4)) dut (.i_clk(clk), .i_nrst(nrst),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
    .i_pwdata(pw), .o_pready(pready), .o_prdata(prd), .o_pslverr(serr),
    .i_questionable_summary_cond(qc), .i_meas_volt(meas), .i_err_valid(ev),
    .i_err_code(ec), .i_err_local(el), .o_volt_set(vset),
    .o_curr_set(cset), .o_output_on(on), .o_questionable_summary(qs),
    .o_local_err_valid(lv), .o_local_err(le));
  stpc_plant_model plant (.i_clk(clk), .i_on(on), .i_set(vset),
    .i_surge(surge), .o_meas(meas));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pw <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prd;
    se = serr;
    psel <= 0;
    pen <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic e);
    xfer(1, a, d);
    `CHK("pslverr", e, se)
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(0, a, 0);
    `CHK("prdata", e, q)
  endtask
  task automatic err(input logic [15:0] c, input logic l);
    @(posedge clk);
    ev <= 1;
    ec <= c;
    el <= l;
    @(posedge clk);
    ev <= 0;
    el <= 0;
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    wrap_up;
  end

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1;
    rd(`STPC_FALL_MASK_OFS, 0);
    rd(`STPC_TRIG_SRC_OFS, `STPC_TRIG_SRC_BUS);
    wr(`STPC_TRIG_SRC_OFS, 1, 1);
    rd(`STPC_ERR_QUEUE_OFS, `STPC_ERR_NONE);
    rd(`STPC_PENDING_VOLTAGE_LEVEL_OFS, 0);
    wr(12'h044, 0, 1);
    rd(`STPC_RISE_MASK_OFS, 0);
    wr(`STPC_RISE_MASK_OFS, `STPC_MASK_MAX, 0);
    wr(`STPC_RISE_MASK_OFS, `STPC_MASK_MAX + 1, 1);
    rd(`STPC_RISE_MASK_OFS, `STPC_MASK_MAX);
    wr(`STPC_RISE_MASK_OFS, 'h000a, 0);
    wr(`STPC_FALL_MASK_OFS, 'h000c, 0);
    rd(`STPC_QUESTIONABLE_SUMMARY_EVENT_OFS, 'h000c);
    qc <= 15'h001f;
    repeat (8) @(posedge clk);
    rd(`STPC_QUESTIONABLE_SUMMARY_COND_OFS, 'h003e);
    rd(`STPC_QUESTIONABLE_SUMMARY_EVENT_OFS, 'h000a);
    rd(`STPC_QUESTIONABLE_SUMMARY_EVENT_OFS, 0);
    wr(`STPC_RISE_MASK_OFS, 'h002a, 0);
    rd(`STPC_QUESTIONABLE_SUMMARY_EVENT_OFS, 'h0020);
    wr(`STPC_QUESTIONABLE_SUMMARY_ENABLE_OFS, 'h0004, 0);
    qc <= 0;
    repeat (8) @(posedge clk);
    `CHK("summary", 1'b1, qs)
    rd(`STPC_STATUS_BYTE_OFS, 'h0008);
    rd(`STPC_QUESTIONABLE_SUMMARY_EVENT_OFS, 'h000c);
    rd(`STPC_STATUS_BYTE_OFS, 0);
    err('h0101, 0);
    err('h0bad, 1);
    #1 `CHK("local", 17'h10bad, {lv, le})
    err('h0102, 0);
    rd(`STPC_ERR_QUEUE_OFS, 'h0101);
    rd(`STPC_ERR_QUEUE_OFS, 'h0102);
    rd(`STPC_ERR_QUEUE_OFS, 0);
    for (int i = 1; i <= 6; i++) err(16'(i), 0);
    for (int i = 1; i <= 3; i++) rd(`STPC_ERR_QUEUE_OFS, i);
    rd(`STPC_ERR_QUEUE_OFS, `STPC_ERR_OVERFLOW);
    wr(`STPC_VOLT_IMM_OFS, 'h0110, 0);
    wr(`STPC_CURR_IMM_OFS, 'h0020, 0);
    wr(`STPC_PENDING_VOLTAGE_LEVEL_OFS, 'h0200, 0);
    wr(`STPC_PENDING_CURRENT_LEVEL_OFS, 'h0040, 0);
    wr(`STPC_VOLT_IMM_OFS, 'h0120, 0);
    rd(`STPC_PENDING_VOLTAGE_LEVEL_OFS, 'h0200);
    wr(`STPC_CMD_OFS, 2, 0);
    rd(`STPC_OPER_COND_OFS, 0);
    `CHK("volt", 16'h0120, vset)
    wr(`STPC_CMD_OFS, 1, 0);
    rd(`STPC_OPER_COND_OFS, 'h0020);
    wr(`STPC_CMD_OFS, 2, 0);
    rd(`STPC_OPER_COND_OFS, 0);
    `CHK("levels", 32'h02000040, {vset, cset})
    wr(`STPC_CONFIG_OFS, 'h3, 0);
    wr(`STPC_PENDING_VOLTAGE_LEVEL_OFS, 'h0250, 0);
    wr(`STPC_CMD_OFS, 2, 0);
    rd(`STPC_OPER_COND_OFS, 'h0020);
    `CHK("volt", 16'h0250, vset)
    wr(`STPC_CONFIG_OFS, 'h2, 0);
    wr(`STPC_VOLT_IMM_OFS, 'h0180, 0);
    wr(`STPC_PENDING_VOLTAGE_LEVEL_OFS, 'h0260, 0);
    wr(`STPC_CMD_OFS, 4, 0);
    rd(`STPC_PENDING_VOLTAGE_LEVEL_OFS, 'h0180);
    wr(`STPC_OV_LIMIT_OFS, 'h0200, 0);
    repeat (3) @(posedge clk);
    `CHK("output", 1'b1, on)
    surge <= 'h0300;
    repeat (3) @(posedge clk);
    `CHK("output", 1'b0, on)
    rd(`STPC_QUESTIONABLE_SUMMARY_COND_OFS, 'h0001);
    wr(`STPC_CMD_OFS, 8, 0);
    rd(`STPC_QUESTIONABLE_SUMMARY_COND_OFS, 'h0001);
    surge <= 0;
    repeat (3) @(posedge clk);
    wr(`STPC_CMD_OFS, 8, 0);
    repeat (2) @(posedge clk);
    `CHK("output", 1'b1, on)
    wrap_up;
  end
endmodule // tb

`default_nettype wire
